// [hw/flash_cmd_pkg.sv]
// constants for the erase / write-latch / register / suspend command block
// assumes a 50 MHz core clock and a link clock well below a quarter of it
package flash_cmd_pkg;

	// opcodes
	localparam logic [7:0] OP_BLK32      = 8'h52;
	localparam logic [7:0] OP_BLK32_4B   = 8'h5C;
	localparam logic [7:0] OP_BLK64      = 8'hD8;
	localparam logic [7:0] OP_BLK64_4B   = 8'hDC;
	localparam logic [7:0] OP_CHIP_A     = 8'hC7;
	localparam logic [7:0] OP_CHIP_B     = 8'h60;
	localparam logic [7:0] OP_SET_WEL    = 8'h06;
	localparam logic [7:0] OP_CLR_WEL    = 8'h04;
	localparam logic [7:0] OP_RD_STATUS  = 8'h05;
	localparam logic [7:0] OP_WR_STATUS  = 8'h01;
	localparam logic [7:0] OP_RD_FUNC    = 8'h48;
	localparam logic [7:0] OP_WR_FUNC    = 8'h42;
	localparam logic [7:0] OP_QUAD_ENTER = 8'h35;
	localparam logic [7:0] OP_QUAD_EXIT  = 8'hF5;
	localparam logic [7:0] OP_SUSP_A     = 8'h75;
	localparam logic [7:0] OP_SUSP_B     = 8'hB0;
	localparam logic [7:0] OP_RESUME_A   = 8'h7A;
	localparam logic [7:0] OP_RESUME_B   = 8'h30;

	// status register layout
	localparam int SR_WIP  = 0;
	localparam int SR_WEL  = 1;
	localparam int SR_BP_LO = 2;
	localparam int SR_QE   = 6;
	localparam int SR_STATUS_WRITE_DISABLE = 7;
	localparam logic [7:0] SR_WRITE_MASK = 8'hFC;   // bp, qe, status_write_disable
	localparam logic [7:0] SR_RESET      = 8'h00;

	// function register layout
	localparam int FR_RST_DIS = 0;
	localparam int FR_PROGRAM_SUSPENDED_FLAG    = 2;
	localparam int FR_ERASE_SUSPENDED_FLAG    = 3;
	localparam int FR_IRL_LO  = 4;
	localparam logic [7:0] FR_OTP_MASK = 8'hF1;     // reset-pin disable and info row locks
	localparam logic [7:0] FR_RESET    = 8'h00;

	// address widths and block sizes
	localparam logic [2:0] ADDR_BYTES_3 = 3'h3;
	localparam logic [2:0] ADDR_BYTES_4 = 3'h4;
	localparam int BLK32_BITS = 15;
	localparam int BLK64_BITS = 16;

	// suspend latency
	localparam int CLK_MHZ = 50;
	localparam int TSUS_US = 100;
	localparam int TSUS_CYC = TSUS_US * CLK_MHZ;

	// plain defaults for array operation times
	localparam int BLK_ERASE_CYC  = 20000;
	localparam int CHIP_ERASE_CYC = 200000;
	localparam int PGM_CYC        = 4000;

	typedef enum logic [2:0] {PH_IDLE, PH_OP, PH_ADDR, PH_DATA, PH_OUT, PH_DONE, PH_BAD} phase_t;
	typedef enum logic [1:0] {OPK_NONE, OPK_BLK, OPK_CHIP, OPK_PGM} op_kind_t;

endpackage

// [hw/flash_cmd_core.sv]
// serial command front end for erase, write latch, status/function registers,
// quad command mode and program/erase suspend
// assumes sck, cs_n and io come from the host in spi mode 0 and are asynchronous
// to clk_i; the array itself sits outside and follows op_active_o / op_addr_o
`timescale 1ns/1ps

module flash_cmd_core #(
	parameter int SUS_CYC   = flash_cmd_pkg::TSUS_CYC,        // suspend-to-ready wait
	parameter int BLK_CYC   = flash_cmd_pkg::BLK_ERASE_CYC,   // block erase time
	parameter int CHIP_CYC  = flash_cmd_pkg::CHIP_ERASE_CYC,  // chip erase time
	parameter int PROG_CYC  = flash_cmd_pkg::PGM_CYC          // page program time
) (
	input  wire logic        clk_i,          // core clock
	input  wire logic        srst_i,         // sync reset, high
	input  wire logic        cs_n_i,         // chip select pin, low active
	input  wire logic        sck_i,          // serial clock pin
	input  wire logic [3:0]  io_i,           // io pins, input side
	output logic      [3:0]  io_o,           // io pins, output side
	output logic      [3:0]  io_oe_o,        // io output enables
	input  wire logic        ext_addr_i,     // extended address mode
	input  wire logic        pgm_req_i,      // page program request pulse
	input  wire logic [31:0] pgm_addr_i,     // page program address
	output logic             pgm_accept_o,   // program request taken
	input  wire logic [31:0] rd_addr_i,      // array read address to check
	output logic             rd_refused_o,   // read hits suspended region
	input  wire logic        clr_err_i,      // clear error flags pulse
	output logic             wip_o,          // write in progress
	output logic             wel_o,          // write enable latch
	output logic             quad_mode_o,    // four-bit command mode
	output logic      [7:0]  status_o,       // status register
	output logic      [7:0]  func_o,         // function register
	output logic             erase_err_o,    // erase error flag
	output logic             prot_err_o,     // protection error flag
	output logic             op_active_o,    // array operation running
	output logic      [1:0]  op_kind_o,      // kind of operation
	output logic      [31:0] op_addr_o       // target base address
);

	// pin synchronisers; stage 1 feeds only stage 2
	logic       sck_s1_ff, sck_s2_ff, sck_s3_ff;
	logic       cs_s1_ff, cs_s2_ff, cs_s3_ff;
	logic [3:0] io_s1_ff, io_s2_ff;

	always_ff @(posedge clk_i) begin
		sck_s1_ff <= sck_i;
		sck_s2_ff <= sck_s1_ff;
		sck_s3_ff <= sck_s2_ff;
		cs_s1_ff  <= cs_n_i;
		cs_s2_ff  <= cs_s1_ff;
		cs_s3_ff  <= cs_s2_ff;
		io_s1_ff  <= io_i;
		io_s2_ff  <= io_s1_ff;
	end

	// block base: low bits inside the block do not matter
	function automatic logic [31:0] blk_base(input logic [31:0] a, input logic [7:0] op);
		logic [31:0] m;
		m = '1;
		if (op == flash_cmd_pkg::OP_BLK32 || op == flash_cmd_pkg::OP_BLK32_4B) begin
			m = ~((32'h1 << flash_cmd_pkg::BLK32_BITS) - 32'h1);
		end else if (op == flash_cmd_pkg::OP_BLK64 || op == flash_cmd_pkg::OP_BLK64_4B) begin
			m = ~((32'h1 << flash_cmd_pkg::BLK64_BITS) - 32'h1);
		end
		return a & m;
	endfunction

	flash_cmd_pkg::phase_t   phase_ff;
	flash_cmd_pkg::op_kind_t kind_ff;
	logic [7:0]  opcode_ff, shift_ff, data_ff, out_sr_ff, sr_ff, fr_ff, blk_op_ff;
	logic [3:0]  bcnt_ff, ocnt_ff, io_o_ff, io_oe_ff;
	logic [2:0]  abytes_ff, aneed_ff;
	logic [31:0] addr_ff, op_addr_ff, op_cnt_ff, sus_cnt_ff;
	logic        wel_ff, quad_ff, erase_suspended_flag_ff, program_suspended_flag_ff, eerr_ff, perr_ff;

	// edge detection and byte assembly
	wire        sck_rise  = sck_s2_ff & ~sck_s3_ff & ~cs_s2_ff;
	wire        sck_fall  = ~sck_s2_ff & sck_s3_ff & ~cs_s2_ff;
	wire        cs_fall   = ~cs_s2_ff & cs_s3_ff;
	wire        cs_rise   = cs_s2_ff & ~cs_s3_ff;
	wire [3:0]  step      = quad_ff ? 4'h4 : 4'h1;
	wire [3:0]  nxt_bcnt  = bcnt_ff + step;
	wire        byte_done = sck_rise & nxt_bcnt[3];
	wire [7:0]  nxt_byte  = quad_ff ? {shift_ff[3:0], io_s2_ff} : {shift_ff[6:0], io_s2_ff[0]};
	wire        suspended = erase_suspended_flag_ff | program_suspended_flag_ff;
	wire        running   = (kind_ff != flash_cmd_pkg::OPK_NONE) & ~suspended;
	wire        sus_wait  = sus_cnt_ff != 32'h0;
	wire        busy      = running | sus_wait;
	wire [3:0]  bp        = sr_ff[flash_cmd_pkg::SR_BP_LO +: 4];
	wire [7:0]  status    = {sr_ff[7:2], wel_ff, busy};
	wire [7:0]  func      = {fr_ff[7:4], erase_suspended_flag_ff, program_suspended_flag_ff, fr_ff[1:0]};

	// opcode classes
	wire [7:0]  b = nxt_byte;
	wire is_blk4  = b == flash_cmd_pkg::OP_BLK32_4B || b == flash_cmd_pkg::OP_BLK64_4B;
	wire is_blk   = is_blk4 || b == flash_cmd_pkg::OP_BLK32 || b == flash_cmd_pkg::OP_BLK64;
	wire is_read  = b == flash_cmd_pkg::OP_RD_STATUS || b == flash_cmd_pkg::OP_RD_FUNC;
	wire is_wreg  = b == flash_cmd_pkg::OP_WR_STATUS || b == flash_cmd_pkg::OP_WR_FUNC;
	wire is_susp  = b == flash_cmd_pkg::OP_SUSP_A || b == flash_cmd_pkg::OP_SUSP_B;
	wire is_res   = b == flash_cmd_pkg::OP_RESUME_A || b == flash_cmd_pkg::OP_RESUME_B;
	wire is_chip  = b == flash_cmd_pkg::OP_CHIP_A || b == flash_cmd_pkg::OP_CHIP_B;
	wire is_bare  = is_chip || is_susp || is_res || b == flash_cmd_pkg::OP_SET_WEL
		|| b == flash_cmd_pkg::OP_CLR_WEL
		|| (b == flash_cmd_pkg::OP_QUAD_ENTER && !quad_ff)
		|| (b == flash_cmd_pkg::OP_QUAD_EXIT && quad_ff);
	// while busy only status/function register reads and suspend get through
	wire ok_busy  = is_read || is_susp;

	// next phase after each completed byte
	flash_cmd_pkg::phase_t nxt_phase;
	always_comb begin
		nxt_phase = phase_ff;
		case (phase_ff)
			flash_cmd_pkg::PH_OP: begin
				if (busy && !ok_busy) begin
					nxt_phase = flash_cmd_pkg::PH_BAD;
				end else if (is_blk) begin
					nxt_phase = flash_cmd_pkg::PH_ADDR;
				end else if (is_read) begin
					nxt_phase = flash_cmd_pkg::PH_OUT;
				end else if (is_wreg) begin
					nxt_phase = flash_cmd_pkg::PH_DATA;
				end else if (is_bare) begin
					nxt_phase = flash_cmd_pkg::PH_DONE;
				end else begin
					nxt_phase = flash_cmd_pkg::PH_BAD;
				end
			end
			flash_cmd_pkg::PH_ADDR: begin
				if (abytes_ff + 3'h1 == aneed_ff) begin
					nxt_phase = flash_cmd_pkg::PH_DONE;
				end
			end
			flash_cmd_pkg::PH_DATA: begin
				nxt_phase = flash_cmd_pkg::PH_DONE;
			end
			default: begin
				nxt_phase = phase_ff;
			end
		endcase
	end

	// serial phase tracking; a clock edge after the command is complete spoils it
	always_ff @(posedge clk_i) begin
		if (srst_i || cs_s2_ff) begin
			phase_ff <= flash_cmd_pkg::PH_IDLE;
			bcnt_ff  <= 4'h0;
			abytes_ff <= 3'h0;
		end else if (cs_fall) begin
			phase_ff <= flash_cmd_pkg::PH_OP;
			addr_ff  <= 32'h0;   // three-byte forms must not inherit a stale top byte
		end else if (sck_rise && phase_ff == flash_cmd_pkg::PH_DONE) begin
			phase_ff <= flash_cmd_pkg::PH_BAD;
		end else if (sck_rise) begin
			shift_ff <= nxt_byte;
			bcnt_ff  <= nxt_bcnt[3] ? 4'h0 : nxt_bcnt;
			if (byte_done) begin
				phase_ff <= nxt_phase;
				if (phase_ff == flash_cmd_pkg::PH_OP) begin
					opcode_ff <= nxt_byte;
					aneed_ff  <= (is_blk4 || ext_addr_i) ? flash_cmd_pkg::ADDR_BYTES_4
						: flash_cmd_pkg::ADDR_BYTES_3;
				end
				if (phase_ff == flash_cmd_pkg::PH_ADDR) begin
					addr_ff   <= {addr_ff[23:0], nxt_byte};
					abytes_ff <= abytes_ff + 3'h1;
				end
				if (phase_ff == flash_cmd_pkg::PH_DATA) begin
					data_ff <= nxt_byte;
				end
			end
		end
	end

	// read-out on falling sck; the value reloads each byte so polling sees live wip
	wire [7:0] out_src = (ocnt_ff == 4'h0)
		? ((opcode_ff == flash_cmd_pkg::OP_RD_STATUS) ? status : func) : out_sr_ff;
	wire [3:0] nxt_ocnt = ocnt_ff + step;
	always_ff @(posedge clk_i) begin
		if (srst_i || cs_s2_ff) begin
			ocnt_ff  <= 4'h0;
			io_o_ff  <= 4'h0;
			io_oe_ff <= 4'h0;
		end else if (sck_fall && phase_ff == flash_cmd_pkg::PH_OUT) begin
			io_o_ff   <= quad_ff ? out_src[7:4] : {2'b00, out_src[7], 1'b0};
			io_oe_ff  <= quad_ff ? 4'hF : 4'h2;   // so is io[1] in single-bit mode
			out_sr_ff <= quad_ff ? {out_src[3:0], 4'h0} : {out_src[6:0], 1'b0};
			ocnt_ff   <= nxt_ocnt[3] ? 4'h0 : nxt_ocnt;
		end
	end

	// command execution at chip-select rise
	wire done_cmd  = cs_rise && phase_ff == flash_cmd_pkg::PH_DONE;
	wire [7:0] oc  = opcode_ff;
	wire x_set     = done_cmd && oc == flash_cmd_pkg::OP_SET_WEL;
	wire x_clr     = done_cmd && oc == flash_cmd_pkg::OP_CLR_WEL;
	wire x_wsr     = done_cmd && oc == flash_cmd_pkg::OP_WR_STATUS && wel_ff && !suspended;
	wire x_wfr     = done_cmd && oc == flash_cmd_pkg::OP_WR_FUNC && wel_ff;
	wire x_qin     = done_cmd && oc == flash_cmd_pkg::OP_QUAD_ENTER;
	wire x_qout    = done_cmd && oc == flash_cmd_pkg::OP_QUAD_EXIT && sr_ff[flash_cmd_pkg::SR_QE];
	wire blk_op    = oc == flash_cmd_pkg::OP_BLK32 || oc == flash_cmd_pkg::OP_BLK32_4B
		|| oc == flash_cmd_pkg::OP_BLK64 || oc == flash_cmd_pkg::OP_BLK64_4B;
	wire chip_op   = oc == flash_cmd_pkg::OP_CHIP_A || oc == flash_cmd_pkg::OP_CHIP_B;
	// a program taken from the side port during the frame keeps running; the erase is dropped
	wire x_blk     = done_cmd && blk_op && wel_ff && !suspended && !busy;
	wire x_chip    = done_cmd && chip_op && wel_ff && !suspended && !busy && bp == 4'h0;
	wire x_chipbad = done_cmd && chip_op && wel_ff && !suspended && !busy && bp != 4'h0;
	wire x_susp    = done_cmd && (oc == flash_cmd_pkg::OP_SUSP_A || oc == flash_cmd_pkg::OP_SUSP_B)
		&& running && kind_ff != flash_cmd_pkg::OPK_CHIP;
	wire x_res     = done_cmd && (oc == flash_cmd_pkg::OP_RESUME_A || oc == flash_cmd_pkg::OP_RESUME_B)
		&& suspended && !sus_wait;
	// an erase starting in the same cycle wins, so the program request must retry
	assign pgm_accept_o = pgm_req_i && wel_ff && !busy && !suspended && !x_blk && !x_chip;
	wire op_end    = running && op_cnt_ff == 32'h1;

	// latch, mode and register bits
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wel_ff  <= 1'b0;
			quad_ff <= 1'b0;
			sr_ff   <= flash_cmd_pkg::SR_RESET;
			fr_ff   <= flash_cmd_pkg::FR_RESET;
		end else begin
			if (x_set) begin
				wel_ff <= 1'b1;
			end else if (x_clr || x_wsr || x_wfr || x_chipbad || x_susp || op_end) begin
				wel_ff <= 1'b0;
			end
			if (x_qin) begin
				quad_ff <= 1'b1;
			end else if (x_qout) begin
				quad_ff <= 1'b0;
			end
			if (x_wsr) begin
				sr_ff <= data_ff & flash_cmd_pkg::SR_WRITE_MASK;
			end
			if (x_wfr) begin
				fr_ff <= fr_ff | (data_ff & flash_cmd_pkg::FR_OTP_MASK);
			end
		end
	end

	// error flags: a new error wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			eerr_ff <= 1'b0;
			perr_ff <= 1'b0;
		end else if (x_chipbad) begin
			eerr_ff <= 1'b1;
			perr_ff <= 1'b1;
		end else if (clr_err_i) begin
			eerr_ff <= 1'b0;
			perr_ff <= 1'b0;
		end
	end

	// array operation engine: one operation; block erase and program pausable by suspend
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			kind_ff    <= flash_cmd_pkg::OPK_NONE;
			op_cnt_ff  <= 32'h0;
			op_addr_ff <= 32'h0;
			blk_op_ff  <= 8'h00;
			erase_suspended_flag_ff    <= 1'b0;
			program_suspended_flag_ff    <= 1'b0;
			sus_cnt_ff <= 32'h0;
		end else begin
			if (x_blk) begin
				kind_ff    <= flash_cmd_pkg::OPK_BLK;
				op_cnt_ff  <= 32'(BLK_CYC);
				op_addr_ff <= blk_base(addr_ff, oc);
				blk_op_ff  <= oc;
			end else if (x_chip) begin
				// runs only with bp clear; a protected chip erase sets both error flags and does not start
				kind_ff    <= flash_cmd_pkg::OPK_CHIP;
				op_cnt_ff  <= 32'(CHIP_CYC);
				op_addr_ff <= 32'h0;
			end else if (pgm_accept_o) begin
				kind_ff    <= flash_cmd_pkg::OPK_PGM;
				op_cnt_ff  <= 32'(PROG_CYC);
				op_addr_ff <= pgm_addr_i;
			end else if (op_end) begin
				kind_ff   <= flash_cmd_pkg::OPK_NONE;
				op_cnt_ff <= 32'h0;
			end else if (running) begin
				op_cnt_ff <= op_cnt_ff - 32'h1;
			end
			if (x_susp) begin
				erase_suspended_flag_ff    <= kind_ff == flash_cmd_pkg::OPK_BLK;
				program_suspended_flag_ff    <= kind_ff == flash_cmd_pkg::OPK_PGM;
				sus_cnt_ff <= 32'(SUS_CYC);
			end else begin
				if (x_res) begin
					erase_suspended_flag_ff <= 1'b0;
					program_suspended_flag_ff <= 1'b0;
				end
				if (sus_wait) begin
					sus_cnt_ff <= sus_cnt_ff - 32'h1;
				end
			end
		end
	end

	// reads into the suspended block or page are refused
	wire [31:0] rd_blk  = blk_base(rd_addr_i, blk_op_ff);
	wire [31:0] rd_page = {rd_addr_i[31:8], 8'h00};
	assign rd_refused_o = (erase_suspended_flag_ff && rd_blk == op_addr_ff)
		|| (program_suspended_flag_ff && rd_page == {op_addr_ff[31:8], 8'h00});

	// outputs
	assign io_o        = io_o_ff;
	assign io_oe_o     = io_oe_ff;
	assign wip_o       = busy;
	assign wel_o       = wel_ff;
	assign quad_mode_o = quad_ff;
	assign status_o    = status;
	assign func_o      = func;
	assign erase_err_o = eerr_ff;
	assign prot_err_o  = perr_ff;
	assign op_active_o = running;
	assign op_kind_o   = kind_ff;
	assign op_addr_o   = op_addr_ff;

endmodule

// [tb/flash_cmd_sva.sv]
// assertions on the ports of the erase / latch / suspend command block
// assumes one clk_i domain with srst_i synchronous; bound after the module
`timescale 1ns/1ps
module flash_cmd_sva (
	input wire logic        clk_i,       // core clock
	input wire logic        srst_i,      // sync reset
	input wire logic        cs_n_i,      // chip select pin
	input wire logic        wip_o,       // write in progress
	input wire logic        wel_o,       // write latch
	input wire logic        quad_mode_o, // four-bit mode
	input wire logic [7:0]  status_o,    // status register
	input wire logic [7:0]  func_o,      // function register
	input wire logic        erase_err_o, // erase error
	input wire logic        prot_err_o,  // protection error
	input wire logic        op_active_o, // op running
	input wire logic [1:0]  op_kind_o,   // op kind
	input wire logic [31:0] op_addr_o    // op base
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	a_done_clears_latch: assert property ($fell(op_active_o) |-> ##[0:2] !wel_o)
		else $error("write latch still set after operation stopped");
	a_busy_shows_wip: assert property (op_active_o |-> wip_o && status_o[0])
		else $error("operation running without write in progress");
	a_otp_bits_stick: assert property (!$past(srst_i) |-> (($past(func_o) & ~func_o) & 8'hF1) == 8'h00)
		else $error("one-time bit returned to zero");
	a_chip_not_suspended: assert property (op_active_o && op_kind_o == 2'h2 |-> func_o[3:2] == 2'b00)
		else $error("suspend flag set during chip erase");
	a_program_suspended_flag_pauses_op: assert property (func_o[2] |-> !op_active_o)
		else $error("operation runs while program suspended");
	a_erase_suspended_flag_pauses_erase: assert property (func_o[3] |-> !(op_active_o && op_kind_o != 2'h3))
		else $error("erase runs while erase suspended");
	a_errors_together: assert property ($rose(prot_err_o) |-> erase_err_o)
		else $error("protection error without erase error");
	a_latch_after_frame: assert property ($rose(wel_o) |-> $past(cs_n_i, 2))
		else $error("latch set while frame still open");
	a_erase_starts_on_rise: assert property ($rose(op_active_o) && op_kind_o != 2'h3 |-> $past(cs_n_i, 2))
		else $error("erase started inside a frame");
	a_block_base_aligned: assert property (op_active_o && op_kind_o == 2'h1 |-> op_addr_o[14:0] == 15'h0)
		else $error("block base not aligned");
	a_suspend_clears_latch: assert property ($rose(func_o[3]) || $rose(func_o[2]) |-> ##[0:1] !wel_o)
		else $error("latch still set after suspend");
	a_reset_state: assert property ($fell(srst_i) |-> !wel_o && !quad_mode_o)
		else $error("latch or quad mode set after reset");

	// main scenarios reached
	c_erase_suspend: cover property ($rose(func_o[3]));
	c_quad_entry: cover property ($rose(quad_mode_o));
	c_chip_erase: cover property (op_active_o && op_kind_o == 2'h2);
endmodule

bind flash_cmd_core flash_cmd_sva flash_cmd_sva_i (.clk_i(clk_i), .srst_i(srst_i), .cs_n_i(cs_n_i),
	.wip_o(wip_o), .wel_o(wel_o), .quad_mode_o(quad_mode_o), .status_o(status_o), .func_o(func_o),
	.erase_err_o(erase_err_o), .prot_err_o(prot_err_o), .op_active_o(op_active_o),
	.op_kind_o(op_kind_o), .op_addr_o(op_addr_o));

// [tb/host_spi_model.sv]
// host flash controller: frames commands on chip select, clock and io lines
// assumes the bench calls one task at a time; sck idles low, 160 ns period
`timescale 1ns/1ps
module host_spi_model (
	output logic            cs_n_o,  // chip select, low active
	output logic            sck_o,   // serial clock
	output logic      [3:0] io_o,    // io lines towards device
	input  wire logic [3:0] dev_io_i // device io drive values
);
	logic quad = 1'b0; // nibble framing once four-bit mode is on

	// idle: deselected, clock still, io not held
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		io_o = 4'hA;
	end

	task automatic start();
		cs_n_o = 1'b0;
		#100;
	endtask

	// data changes while sck low; reply taken late in the high phase
	// so the device has had its full drive delay after the fall
	task automatic xbyte(input logic [7:0] b, output logic [7:0] r);
		for (int i = 0; i < (quad ? 2 : 8); i++) begin
			io_o = quad ? (i == 0 ? b[7:4] : b[3:0]) : {3'h0, b[7 - i]};
			#80 sck_o = 1'b1;
			#60 r = quad ? {r[3:0], dev_io_i} : {r[6:0], dev_io_i[1]};
			#20 sck_o = 1'b0;
		end
	endtask

	// released lines float, so show the inverse instead of the last value
	task automatic stop();
		#100 cs_n_o = 1'b1;
		io_o = ~io_o;
		#300;
	endtask
endmodule

// [tb/flash_erase_write_suspend_cmds_tb.sv]
// self-checking bench for the serial erase / latch / suspend command block
// assumes host_spi_model and the bound checker are compiled before it
`timescale 1ns/1ps
`define CMP(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("ERROR %0t: got %h want %h", $time, g, e); end end
module flash_erase_write_suspend_cmds_tb;
	typedef struct {int sel; logic [31:0] exp;} note_t;
	logic        clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic        cs_n, sck, pgm_accept, rd_refused, write_in_progress, write_enable_latch, quad, erase_err, prot_err, op_active;
	logic [3:0]  io_in, io_out, io_oe;
	logic        ext_addr_i = 1'b0;
	logic        pgm_req_i = 1'b0;
	logic        clr_err_i = 1'b0;
	logic [31:0] pgm_addr_i = 32'h0;
	logic [31:0] rd_addr_i = 32'h0;
	logic [1:0]  op_kind;
	logic [7:0]  status, func, rd_byte;
	logic [31:0] op_addr;
	logic [31:0] seed = 32'h01BD1066;
	int          failures = 0;
	int          cmp_count = 0;
	note_t       notes[$];
	event        look;

	host_spi_model host_spi_model_i (.cs_n_o(cs_n), .sck_o(sck), .io_o(io_in), .dev_io_i(io_out));

	// short array times so that a run stays brief
	flash_cmd_core #(.SUS_CYC(100), .BLK_CYC(2000), .CHIP_CYC(3000), .PROG_CYC(1500)) flash_cmd_core_i (
		.clk_i(clk_i), .srst_i(srst_i), .cs_n_i(cs_n), .sck_i(sck), .io_i(io_in), .io_o(io_out),
		.io_oe_o(io_oe), .ext_addr_i(ext_addr_i), .pgm_req_i(pgm_req_i), .pgm_addr_i(pgm_addr_i),
		.pgm_accept_o(pgm_accept), .rd_addr_i(rd_addr_i), .rd_refused_o(rd_refused), .clr_err_i(clr_err_i),
		.wip_o(write_in_progress), .wel_o(write_enable_latch), .quad_mode_o(quad), .status_o(status), .func_o(func),
		.erase_err_o(erase_err), .prot_err_o(prot_err), .op_active_o(op_active), .op_kind_o(op_kind),
		.op_addr_o(op_addr));

	initial forever #10 clk_i = ~clk_i;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// output groups that a note can name
	function automatic logic [31:0] pick(input int s);
		case (s)
			0: return {24'h0, status};
			1: return {24'h0, func};
			2: return {20'h0, io_oe, rd_refused, pgm_accept, quad, prot_err, erase_err, op_kind, op_active};
			3: return op_addr;
			4: return {24'h0, rd_byte};
			5: return {31'h0, rd_refused};
			7: return {31'h0, write_enable_latch};
			default: return {24'h0, status & 8'hFC};
		endcase
	endfunction

	task automatic note(input int s, input logic [31:0] e);
		notes.push_back('{s, e});
		-> look;
		#1;
	endtask

	// oldest note is judged against the live outputs when a result is flagged
	initial forever begin
		note_t n;
		@(look);
		n = notes.pop_front();
		`CMP(pick(n.sel), n.exp)
	end

	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int na, input logic [7:0] d, input int nd);
		// every frame starts just after an edge so no pin moves on a sampling edge
		@(posedge clk_i);
		#1;
		host_spi_model_i.start();
		host_spi_model_i.xbyte(op, rd_byte);
		for (int i = na - 1; i >= 0; i--) host_spi_model_i.xbyte(a[8 * i +: 8], rd_byte);
		for (int i = 0; i < nd; i++) host_spi_model_i.xbyte(d, rd_byte);
		host_spi_model_i.stop();
	endtask

	task automatic op1(input logic [7:0] op);
		cmd(op, 32'h0, 0, 8'h00, 0);
	endtask

	task automatic wr(input logic [7:0] op, input logic [7:0] d);
		cmd(op, 32'h0, 0, d, 1);
	endtask

	// polls the busy flag instead of a fixed wait; a stuck flag ends the run
	task automatic wait_idle();
		int k;
		k = 0;
		while (write_in_progress === 1'b1 && k < 5000) begin
			@(posedge clk_i);
			k++;
		end
		if (k >= 5000) begin
			failures++;
			end_sim();
		end
		repeat (2) @(posedge clk_i);
	endtask

	// erase suspended mid-run, refused work, then resumed
	task automatic suspend_check(input logic [31:0] base);
		wr(flash_cmd_pkg::OP_RD_STATUS, 8'h00);
		note(4, 32'h3);
		op1(flash_cmd_pkg::OP_SUSP_A);
		note(1, 32'h8);
		note(0, 32'h1);
		op1(flash_cmd_pkg::OP_SET_WEL);
		note(7, 32'h0);
		@(posedge clk_i) rd_addr_i <= base | 32'h7FFF;
		wait_idle();
		note(5, 32'h1);
		op1(flash_cmd_pkg::OP_SET_WEL);
		wr(flash_cmd_pkg::OP_WR_STATUS, 8'h3C);
		note(6, 32'h0);
		op1(flash_cmd_pkg::OP_RESUME_A);
		note(1, 32'h0);
		note(2, 32'h3);
	endtask

	initial begin
		logic [7:0] bops [4];
		logic [31:0] a;
		bops = '{flash_cmd_pkg::OP_BLK32, flash_cmd_pkg::OP_BLK64, flash_cmd_pkg::OP_BLK32_4B, flash_cmd_pkg::OP_BLK64_4B};
		repeat (12) @(posedge clk_i);
		srst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		note(0, 32'h0);
		op1(flash_cmd_pkg::OP_SET_WEL);
		note(0, 32'h2);
		op1(flash_cmd_pkg::OP_CLR_WEL);
		cmd(flash_cmd_pkg::OP_BLK64, 32'h0, 3, 8'h00, 0);
		note(2, 32'h0);
		// every block opcode, both address widths, random targets
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i) ext_addr_i <= i[0];
			seed = lfsr(seed);
			a = (i == 0) ? {8'h00, seed[23:0]} : seed;
			op1(flash_cmd_pkg::OP_SET_WEL);
			cmd(bops[i], seed, (i == 0) ? 3 : 4, 8'h00, 0);
			note(2, 32'h3);
			note(3, a & (i[0] ? 32'hFFFF0000 : 32'hFFFF8000));
			if (i == 0) suspend_check(a & 32'hFFFF8000);
			wait_idle();
			note(0, 32'h0);
		end
		@(posedge clk_i) ext_addr_i <= 1'b0;
		op1(flash_cmd_pkg::OP_SET_WEL);
		cmd(flash_cmd_pkg::OP_BLK32, seed, 4, 8'h00, 0);
		note(2, 32'h0);
		wr(flash_cmd_pkg::OP_WR_STATUS, 8'h04);
		note(6, 32'h4);
		op1(flash_cmd_pkg::OP_SET_WEL);
		op1(flash_cmd_pkg::OP_CHIP_A);
		note(2, 32'h18);
		@(posedge clk_i) clr_err_i <= 1'b1;
		@(posedge clk_i) clr_err_i <= 1'b0;
		op1(flash_cmd_pkg::OP_SET_WEL);
		wr(flash_cmd_pkg::OP_WR_STATUS, 8'h00);
		op1(flash_cmd_pkg::OP_SET_WEL);
		op1(flash_cmd_pkg::OP_CHIP_B);
		note(2, 32'h5);
		op1(flash_cmd_pkg::OP_SUSP_B);
		note(1, 32'h0);
		wait_idle();
		note(0, 32'h0);
		op1(flash_cmd_pkg::OP_SET_WEL);
		wr(flash_cmd_pkg::OP_WR_FUNC, 8'hF1);
		note(1, 32'hF1);
		op1(flash_cmd_pkg::OP_SET_WEL);
		wr(flash_cmd_pkg::OP_WR_FUNC, 8'h00);
		note(1, 32'hF1);
		// program suspended, refused status write and read, resumed
		op1(flash_cmd_pkg::OP_SET_WEL);
		seed = lfsr(seed);
		@(posedge clk_i) pgm_addr_i <= seed;
		@(posedge clk_i) pgm_req_i <= 1'b1;
		#1 note(2, 32'h40);
		@(posedge clk_i) pgm_req_i <= 1'b0;
		op1(flash_cmd_pkg::OP_SUSP_B);
		note(1, 32'hF5);
		wr(flash_cmd_pkg::OP_RD_FUNC, 8'h00);
		note(4, 32'hF5);
		@(posedge clk_i) rd_addr_i <= seed;
		wait_idle();
		note(5, 32'h1);
		op1(flash_cmd_pkg::OP_SET_WEL);
		wr(flash_cmd_pkg::OP_WR_STATUS, 8'h3C);
		note(6, 32'h0);
		op1(flash_cmd_pkg::OP_RESUME_B);
		note(1, 32'hF1);
		wait_idle();
		note(0, 32'h0);
		op1(flash_cmd_pkg::OP_SET_WEL);
		wr(flash_cmd_pkg::OP_WR_STATUS, 8'h40);
		op1(flash_cmd_pkg::OP_QUAD_ENTER);
		note(2, 32'h20);
		host_spi_model_i.quad = 1'b1;
		op1(flash_cmd_pkg::OP_QUAD_EXIT);
		note(2, 32'h0);
		host_spi_model_i.quad = 1'b0;
		end_sim();
	end
endmodule
